// File: design/ttr_regs.vh
/*
 * Constants for the triple 8-bit reload timer block: mode register field
 * positions, reset values and count-source divide figures.
 * Assumes inclusion by the timer design file only.
 */
`ifndef TTR_REGS_VH
`define TTR_REGS_VH

// Mode register fields
`define TTR_MODE_START_LOW   0
`define TTR_MODE_OUT_EN      1
`define TTR_MODE_T2_LATCH    2
`define TTR_MODE_T2_SRC      3
`define TTR_MODE_T3_SRC      4
`define TTR_MODE_T1_SRC      5
`define TTR_MODE_RESET       6'h00

// Counter and latch reset values
`define TTR_CNT_RESET        8'hff
`define TTR_LATCH_RESET      8'hff

// Oscillator prescale
`define TTR_PRESCALE_DIV     16
`define TTR_PRESCALE_MAX     4'hf

`endif

// File: design/ttr_timers.v
/*
 * Three 8-bit down-counting reload timers with a toggling pulse output
 * on the second timer. Registers are plain ports: one write strobe per
 * timer with shared write data, the mode register as a port, counters read back.
 * Timer one counts a divided or sub oscillator source; timers two and
 * three count timer one underflows or the divided source. Each timer
 * has a sticky request flag and a one-cycle request pulse.
 *
 * Assumes oscillator inputs are already synchronous to ref_clk and
 * slower than half its rate, so every source edge is seen.
 * Assumes the write strobes last one cycle each; a longer strobe
 * rewrites the counter, or only the latch for a timer two latch-only write, on every cycle it stands.
 * Assumes clk_en low freezes the whole block, request pulses included.
 * Assumes the pin's direction setting lives outside this block; the
 * drive enable here only follows the output control bit.
 */
// Notes on behaviour
// - Three independent 8-bit counters decrement per count
// - Counting starts by itself after reset release
// - Count at zero underflows and reloads latch
// - Underflow sets sticky request flag and requests
// - Flag clears on acceptance or software clear
// - Underflow every initial value plus one counts
// - Timers one, three: write loads counter and latch
// - Timer two latch-only write reloads at underflow
// - Timer two toggles pulse pin each underflow
// - Pulses appear once output control set
// - Counter and latch share address; read gives counter
// - Latch value is never readable
// - Timer one source: main/16 (sub/16 in low speed) or sub clock
// - Timers two, three: timer one underflow or main/16 (sub/16 in low speed)
// - Start level high when bit zero, else low
// - Output disabled when control bit zero
`timescale 1ns/100ps
`include "ttr_regs.vh"

module ttr_timers #(
    parameter WIDTH = 8
) (
    // Clock, reset, enable
    input wire ref_clk,
    input wire sys_rst,
    input wire clk_en,
    // Oscillators and speed mode
    input wire main_osc_in,
    input wire sub_osc_in,
    input wire low_speed,
    // Mode register
    input wire [5:0] triple_timer_mode_reg,
    // Timer writes
    input wire t1_wr,
    input wire t2_wr,
    input wire t3_wr,
    input wire [WIDTH-1:0] wr_data,
    // Flag clears and interrupt acceptance
    input wire [2:0] irq_flag_clr,
    input wire [2:0] irq_ack,
    // Counter read-back
    output wire [WIDTH-1:0] t1_count,
    output wire [WIDTH-1:0] t2_count,
    output wire [WIDTH-1:0] t3_count,
    // Interrupt requests
    output wire [2:0] irq_flag,
    output wire [2:0] irq_pulse,
    // Pulse output pin
    output wire toggle_pulse_out_pin,
    output wire toggle_pulse_out_en
);

    // Sampled oscillator levels for edge detection
    reg main_q;
    reg sub_q;
    // Prescaler position within sixteen source edges
    reg [3:0] pre_q;
    // Counters, shown on the read-back ports
    reg [WIDTH-1:0] cnt1_q;
    reg [WIDTH-1:0] cnt2_q;
    reg [WIDTH-1:0] cnt3_q;
    // Reload latches, never shown outside
    reg [WIDTH-1:0] lat1_q;
    reg [WIDTH-1:0] lat2_q;
    reg [WIDTH-1:0] lat3_q;
    // Sticky flags and one-cycle request pulses
    reg [2:0] flag_q;
    reg [2:0] pulse_q;
    // Pulse pin level and its drive enable
    reg tog_q;
    reg out_en_q;

    // Count enables and underflow strobes
    wire osc_src;
    wire osc_rise;
    wire sub_rise;
    wire div16_en;
    wire src1_en;
    wire src2_en;
    wire src3_en;
    wire uf1;
    wire uf2;
    wire uf3;
    wire [2:0] uf_all;
    // Write and clear decodes
    wire t2_latch_only;
    wire t2_full_wr;
    wire [2:0] flag_clear;
    // Mode bits by name
    wire start_low;
    wire out_en_req;
    wire t1_sel_sub;
    wire t2_sel_div;
    wire t3_sel_div;
    wire out_en_set;

    // True when a counter holds zero; its next count underflows
    function is_zero;
        input [WIDTH-1:0] cnt;
        begin
            is_zero = (cnt == {WIDTH{1'b0}});
        end
    endfunction

    // Next counter value for one count enable
    function [WIDTH-1:0] next_count;
        input [WIDTH-1:0] cnt;
        input [WIDTH-1:0] lat;
        begin
            if (is_zero(cnt)) begin
                next_count = lat;
            end else begin
                next_count = cnt - {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    endfunction

    // Mode register bits by name
    assign start_low = triple_timer_mode_reg[`TTR_MODE_START_LOW];
    assign out_en_req = triple_timer_mode_reg[`TTR_MODE_OUT_EN];
    assign t2_latch_only = triple_timer_mode_reg[`TTR_MODE_T2_LATCH];
    assign t2_sel_div = triple_timer_mode_reg[`TTR_MODE_T2_SRC];
    assign t3_sel_div = triple_timer_mode_reg[`TTR_MODE_T3_SRC];
    assign t1_sel_sub = triple_timer_mode_reg[`TTR_MODE_T1_SRC];

    // Oscillator edge detection for count enables.
    // Both samplers reset low, the idle level of a stopped oscillator,
    // so no false edge follows reset.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            main_q <= 1'b0;
            sub_q <= 1'b0;
        end else if (clk_en) begin
            main_q <= osc_src;
            sub_q <= sub_osc_in;
        end
    end

    // Low speed mode swaps the divided clock to the sub oscillator.
    // Switching it while the two levels differ can give one stray edge.
    assign osc_src = low_speed ? sub_osc_in : main_osc_in;
    assign osc_rise = osc_src & ~main_q;
    assign sub_rise = sub_osc_in & ~sub_q;

    // Divide by sixteen prescaler on source rising edges.
    // It runs freely from reset, so the first divided enable after a
    // source change may come early; the timers accept that jitter.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pre_q <= 4'h0;
        end else if (clk_en && osc_rise) begin
            pre_q <= pre_q + 4'h1;
        end
    end

    // One enable on every sixteenth source edge
    assign div16_en = osc_rise && (pre_q == `TTR_PRESCALE_MAX);

    // Count source selection; timers two and three may chain on timer one,
    // so a timer one underflow counts them in the same cycle
    assign src1_en = t1_sel_sub ? sub_rise : div16_en;
    assign src2_en = t2_sel_div ? div16_en : uf1;
    assign src3_en = t3_sel_div ? div16_en : uf1;

    // A full write to timer two beats a count in the same cycle
    assign t2_full_wr = t2_wr && !t2_latch_only;

    // Underflow strobes. A timer one or three write, or a full timer two write, in the same cycle
    // replaces the count, so no underflow is reported then; a latch-only underflow still reports.
    assign uf1 = src1_en && is_zero(cnt1_q) && !t1_wr;
    assign uf2 = src2_en && is_zero(cnt2_q) && !t2_full_wr;
    assign uf3 = src3_en && is_zero(cnt3_q) && !t3_wr;
    assign uf_all = {uf3, uf2, uf1};

    // Timer one: a write loads counter and latch together, so a write
    // while counting shortens or stretches the period in progress
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt1_q <= `TTR_CNT_RESET;
            lat1_q <= `TTR_LATCH_RESET;
        end else if (clk_en) begin
            if (t1_wr) begin
                cnt1_q <= wr_data;
                lat1_q <= wr_data;
            end else if (src1_en) begin
                cnt1_q <= next_count(cnt1_q, lat1_q);
            end
        end
    end

    // Timer three: same write behaviour as timer one.
    // It has no pin, only its flag and pulse.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt3_q <= `TTR_CNT_RESET;
            lat3_q <= `TTR_LATCH_RESET;
        end else if (clk_en) begin
            if (t3_wr) begin
                cnt3_q <= wr_data;
                lat3_q <= wr_data;
            end else if (src3_en) begin
                cnt3_q <= next_count(cnt3_q, lat3_q);
            end
        end
    end

    // Timer two: in latch-only mode a write waits for the next underflow.
    // A latch-only write in the underflow cycle itself loads the new value.
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            cnt2_q <= `TTR_CNT_RESET;
            lat2_q <= `TTR_LATCH_RESET;
        end else if (clk_en) begin
            if (t2_wr) begin
                lat2_q <= wr_data;
            end
            if (t2_full_wr) begin
                cnt2_q <= wr_data;
            end else if (uf2 && t2_wr) begin
                cnt2_q <= wr_data;
            end else if (src2_en) begin
                cnt2_q <= next_count(cnt2_q, lat2_q);
            end
        end
    end

    // Either a software clear or an accepted request drops a flag
    assign flag_clear = irq_flag_clr | irq_ack;

    // Sticky flags: underflow wins over a clear in the same cycle
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            flag_q <= 3'h0;
        end else if (clk_en) begin
            flag_q <= uf_all | (flag_q & ~flag_clear);
        end
    end

    // Request pulses: one cycle per underflow, registered
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            pulse_q <= 3'h0;
        end else if (clk_en) begin
            pulse_q <= uf_all;
        end
    end

    // Output enable follows the control bit one cycle later
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            out_en_q <= 1'b0;
        end else if (clk_en) begin
            out_en_q <= out_en_req;
        end
    end

    // Enabling the output loads the start level
    assign out_en_set = out_en_req && !out_en_q;

    // Pin level: start level on enable, then inverts on each timer two
    // underflow; while disabled the level is held
    always @(posedge ref_clk) begin
        if (sys_rst) begin
            tog_q <= 1'b1;
        end else if (clk_en) begin
            if (out_en_set) begin
                tog_q <= ~start_low;
            end else if (uf2 && out_en_q) begin
                tog_q <= ~tog_q;
            end
        end
    end

    // Read-back shows counters only, never latches
    assign t1_count = cnt1_q;
    assign t2_count = cnt2_q;
    assign t3_count = cnt3_q;

    // Interrupt outputs
    assign irq_flag = flag_q;
    assign irq_pulse = pulse_q;

    // Pulse pin and its drive enable
    assign toggle_pulse_out_pin = tog_q;
    assign toggle_pulse_out_en = out_en_q;

endmodule

// File: sim/ttr_checker.sv
/*
 * Port checker for ttr_timers: counter, flag and pulse pin relations.
 * Assumes it is bound to the design and that clk_en low freezes all state.
 */
`timescale 1ns/100ps
module ttr_checker (
    // Clock, reset, enable
    input wire ref_clk,
    input wire sys_rst,
    input wire clk_en,
    // Control inputs
    input wire t1_wr,
    input wire [5:0] triple_timer_mode_reg,
    input wire [7:0] wr_data,
    input wire [2:0] irq_flag_clr,
    input wire [2:0] irq_ack,
    // Watched outputs
    input wire [7:0] t1_count,
    input wire [2:0] irq_flag,
    input wire [2:0] irq_pulse,
    input wire toggle_pulse_out_pin,
    input wire toggle_pulse_out_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst || !clk_en);
    // Counter, flag and pin relations
    write_load_a: assert property (t1_wr |=> t1_count == $past(wr_data))
        else $error("write not loaded");
    count_step_a: assert property (!$past(t1_wr) && !irq_pulse[0]
        && t1_count != $past(t1_count) |-> t1_count == $past(t1_count) - 8'h01)
        else $error("bad step");
    reload_zero_a: assert property (irq_pulse[0] && !$past(t1_wr)
        |-> $past(t1_count) == 8'h00) else $error("underflow not at zero");
    pulse_flag_a: assert property (irq_pulse[1] |-> irq_flag[1])
        else $error("pulse without flag");
    flag_hold_a: assert property (irq_flag[0] && !irq_flag_clr[0] && !irq_ack[0]
        |=> irq_flag[0]) else $error("flag lost");
    flag_clr_a: assert property (irq_flag_clr[2] || irq_ack[2]
        |=> !irq_flag[2] || irq_pulse[2]) else $error("flag not cleared");
    pin_toggle_a: assert property (toggle_pulse_out_en && $past(toggle_pulse_out_en)
        |-> toggle_pulse_out_pin == ($past(toggle_pulse_out_pin) ^ irq_pulse[1]))
        else $error("pin toggle wrong");
    start_level_a: assert property ($rose(toggle_pulse_out_en)
        |-> toggle_pulse_out_pin == !$past(triple_timer_mode_reg[0])) else $error("bad start");
    // Main scenarios reached
    cover property (irq_pulse[0]);
    cover property (irq_pulse[2]);
    cover property ($rose(toggle_pulse_out_en));
endmodule
bind ttr_timers ttr_checker ttr_checker_inst (.ref_clk, .sys_rst, .clk_en, .t1_wr,
    .toggle_pulse_out_pin,
    .toggle_pulse_out_en, .triple_timer_mode_reg, .wr_data, .t1_count, .irq_flag, .irq_pulse,
    .irq_flag_clr, .irq_ack);

// File: sim/triple_8bit_reload_timers_test.sv
/* Bench for ttr_timers; drives every port directly, including clk_en and low_speed. */
`timescale 1ns/100ps
module triple_8bit_reload_timers_test;
    // Stimulus and observed ports
    reg ref_clk = 0, sys_rst = 1, main_osc_in = 0, sub_osc_in = 0, t1_wr = 0, t2_wr = 0, t3_wr = 0;
    reg clk_en = 1, low_speed = 0;
    reg [5:0] mode = 6'h20;
    reg [7:0] wr_data = 8'h00;
    reg [2:0] irq_flag_clr = 3'h0, irq_ack = 3'h0;
    wire [7:0] t1_count, t2_count, t3_count;
    wire [2:0] irq_flag, irq_pulse;
    wire toggle_pulse_out_pin, toggle_pulse_out_en;
    integer num_errors = 0, checks = 0;
    ttr_timers ttr_timers_inst (.ref_clk, .sys_rst, .clk_en, .main_osc_in, .sub_osc_in,
        .low_speed, .triple_timer_mode_reg(mode), .t1_wr, .t2_wr, .t3_wr, .wr_data,
        .irq_flag_clr, .irq_ack, .t1_count, .t2_count, .t3_count, .irq_flag, .irq_pulse,
        .toggle_pulse_out_pin, .toggle_pulse_out_en);
    // Clock at 4 ns period
    always #2 ref_clk = ~ref_clk;
    task tick(input integer n);
        repeat (n) @(posedge ref_clk);
    endtask
    task chk(input [8:0] g, e);
        checks = checks + 1;
        if (g !== e) begin
            num_errors = num_errors + 1;
            $display("unexpected %0t got %h want %h", $time, g, e);
        end
    endtask
    // One write strobe to timer t
    task wr(input integer t, input [7:0] d);
        @(posedge ref_clk);
        wr_data <= d;
        t1_wr <= t == 1; t2_wr <= t == 2; t3_wr <= t == 3;
        @(posedge ref_clk);
        t1_wr <= 0; t2_wr <= 0; t3_wr <= 0;
        #1;
    endtask
    // One rising edge on sub (m=0) or main (m=1) oscillator
    task rise(input m);
        @(posedge ref_clk);
        if (m) main_osc_in <= 1; else sub_osc_in <= 1;
        @(posedge ref_clk);
        main_osc_in <= 0; sub_osc_in <= 0;
        tick(1); #1;
    endtask
    task clr(input [2:0] c, a);
        @(posedge ref_clk);
        irq_flag_clr <= c; irq_ack <= a;
        @(posedge ref_clk);
        irq_flag_clr <= 3'h0; irq_ack <= 3'h0;
        tick(1); #1;
    endtask
    task t_reset;
        chk(t1_count, 8'hff);
        chk({irq_flag, irq_pulse, toggle_pulse_out_pin, toggle_pulse_out_en}, 8'h02);
        rise(0);
        chk(t1_count, 8'hfe);
        $display("reset test done");
    endtask
    task t_t1;
        wr(1, 8'h02);
        chk(t1_count, 8'h02);
        rise(0); rise(0);
        chk({t1_count, irq_flag[0]}, 9'h000);
        rise(0);
        chk({irq_flag[0], t1_count}, 9'h102);
        chk(t2_count, 8'hfe);
        clr(3'h1, 3'h0);
        chk(irq_flag, 3'h0);
        rise(0); rise(0);
        chk(irq_flag, 3'h0);
        rise(0);
        chk(irq_flag, 3'h1);
        clr(3'h0, 3'h1);
        chk(irq_flag, 3'h0);
        $display("timer one test done");
    endtask
    task t_t2;
        wr(2, 8'h01);
        chk(t2_count, 8'h01);
        @(posedge ref_clk);
        mode <= 6'h26;
        tick(2); #1;
        chk({toggle_pulse_out_pin, toggle_pulse_out_en}, 8'h03);
        wr(2, 8'h05);
        chk(t2_count, 8'h01);
        repeat (3) rise(0);
        chk({toggle_pulse_out_pin, t2_count}, 9'h100);
        repeat (3) rise(0);
        chk({toggle_pulse_out_pin, t2_count}, 9'h005);
        chk(irq_flag[1], 1'b1);
        $display("timer two test done");
    endtask
    task t_t3;
        @(posedge ref_clk);
        mode <= 6'h30;
        wr(3, 8'h00);
        chk(t3_count, 8'h00);
        repeat (15) rise(1);
        chk(irq_flag[2], 1'b0);
        rise(1);
        chk(irq_flag[2], 1'b1);
        clr(3'h4, 3'h0);
        chk(irq_flag[2], 1'b0);
        $display("timer three test done");
    endtask
    // Freeze with clk_en low, then low speed divided source and low start level
    task t_modes;
        @(posedge ref_clk);
        clk_en <= 0;
        rise(0);
        chk(t1_count, 8'h02);
        @(posedge ref_clk);
        clk_en <= 1; low_speed <= 1; mode <= 6'h13;
        tick(2); #1;
        chk({toggle_pulse_out_pin, toggle_pulse_out_en}, 8'h01);
        repeat (15) rise(0);
        chk(t1_count, 8'h02);
        rise(0);
        chk(t1_count, 8'h01);
        $display("mode test done");
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Main sequence
    initial begin
        tick(10);
        sys_rst <= 0;
        tick(1); #1;
        t_reset; t_t1; t_t2; t_t3; t_modes;
        test_done;
    end
    // Watchdog
    initial begin
        #20000;
        num_errors = num_errors + 1;
        test_done;
    end
endmodule
